// file: rtl/sbsr_top.sv
// status summary byte, service request mask and request-true logic
`timescale 1ns/1ns
module sbsr_top
	import sbsr_pkg::*;
(
	input  wire logic       mclk,       // 10 MHz system clock
	input  wire logic       rst,        // asynchronous reset, active high
	input  wire sbsr_cond_t cond,       // queue and event condition sources
	input  wire logic       maskWrite,  // pulse: mask-setting command
	input  wire logic [7:0] maskData,   // new mask value with maskWrite
	input  wire logic       maskQuery,  // pulse: mask query command
	input  wire logic       stbQuery,   // pulse: status byte query command
	input  wire logic       readStb,    // pulse: bus-level Read STB command
	input  wire logic [2:0] levelPins,  // interrupt level select switch pins
	output sbsr_resp_t      resp,       // answer to a read or query
	output logic            reqTrue,    // pulse: request-true interrupt
	output logic [2:0]      reqLevel,   // level that reqTrue is raised on
	output logic            reqPending  // level: latched request awaiting Read STB
);

	typedef struct packed {
		logic [7:0] mask;        // service request mask, bit 6 held zero
		logic       summaryPrev; // last cycle's live summary, for edge detect
		logic       rqsLatch;    // request bit as seen by Read STB
		sbsr_resp_t resp;
		logic       reqTrue;
		logic [2:0] lvlS1;       // level select synchroniser, stage 1
		logic [2:0] lvlS2;
		logic [2:0] lvlS3;
		logic [2:0] level;       // accepted level select
	} sbsr_top_state_t;

	localparam sbsr_top_state_t STATE_RESET = '{
		mask:        MASK_RESET,
		summaryPrev: 1'b0,
		rqsLatch:    1'b0,
		resp:        '{valid: 1'b0, kind: SBSR_ANS_NONE, data: STB_RESET},
		reqTrue:     1'b0,
		lvlS1:       LVL_RESET,
		lvlS2:       LVL_RESET,
		lvlS3:       LVL_RESET,
		level:       LVL_RESET
	};

	sbsr_top_state_t st;
	sbsr_top_state_t next_st;
	logic [7:0]      statusByte;
	logic            summaryLive;
	logic            summaryRise;

	// masked summary of the status byte; bit 6 itself never feeds back
	function automatic logic masked_summary(input logic [7:0] stb, input logic [7:0] mask);
		masked_summary = |(stb & mask & MASK_LIVE_BITS);
	endfunction : masked_summary

	// byte with the request bit put in place
	function automatic logic [7:0] with_rqs(input logic [7:0] stb, input logic rqs);
		logic [7:0] b;
		b = stb;
		b[BIT_RQS] = rqs;
		with_rqs = b;
	endfunction : with_rqs

	sbsr_byte_build sbsr_byte_build_inst (
		.mclk       (mclk),
		.rst        (rst),
		.cond       (cond),
		.statusByte (statusByte)
	);

	// live summary is what the query sees; the latch is what Read STB sees
	assign summaryLive = masked_summary(statusByte, st.mask);
	assign summaryRise = summaryLive && !st.summaryPrev;

	// command handling, request latch and level select in one next-state block
	always_comb
	begin
		next_st = st;
		next_st.summaryPrev = summaryLive;
		next_st.reqTrue = summaryRise;
		next_st.resp.valid = 1'b0;
		next_st.resp.kind = SBSR_ANS_NONE;
		next_st.resp.data = st.resp.data;

		// a new rise in the same cycle as a Read STB keeps the latch set
		next_st.rqsLatch = summaryRise || (st.rqsLatch && !readStb);

		// mask write; bit 6 cannot be stored, unused bits are kept but inert
		if (maskWrite)
			next_st.mask = maskData & MASK_STORE_BITS;

		// one answer per cycle: Read STB wins over the queries
		if (readStb)
		begin
			next_st.resp.valid = 1'b1;
			next_st.resp.kind = SBSR_ANS_READ;
			next_st.resp.data = with_rqs(statusByte, st.rqsLatch);
		end
		else if (stbQuery)
		begin
			next_st.resp.valid = 1'b1;
			next_st.resp.kind = SBSR_ANS_QUERY;
			next_st.resp.data = with_rqs(statusByte, summaryLive);
		end
		else if (maskQuery)
		begin
			next_st.resp.valid = 1'b1;
			next_st.resp.kind = SBSR_ANS_MASK;
			next_st.resp.data = st.mask;
		end

		// switch pins: accept a new level only once stages 2 and 3 agree
		next_st.lvlS1 = levelPins;
		next_st.lvlS2 = st.lvlS1;
		next_st.lvlS3 = st.lvlS2;
		if (st.lvlS2 == st.lvlS3)
			next_st.level = st.lvlS3;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st <= STATE_RESET;
		else
			st <= next_st;
	end

	assign resp       = st.resp;
	assign reqTrue    = st.reqTrue;
	assign reqLevel   = st.level;
	assign reqPending = st.rqsLatch;

	// a rise of the masked summary gives exactly one request pulse next cycle
	req_on_rise_a: assert property (@(posedge mclk) disable iff (rst)
		(summaryLive && !st.summaryPrev) |=> reqTrue ##1 !reqTrue)
		else $error("request-true pulse missing or too long");

	req_has_cause_a: assert property (@(posedge mclk) disable iff (rst)
		reqTrue |-> $past(summaryLive) && !$past(st.summaryPrev))
		else $error("request-true raised without a new summary");

	read_reports_set_a: assert property (@(posedge mclk) disable iff (rst)
		(readStb && st.rqsLatch) |=> resp.valid && resp.kind == SBSR_ANS_READ
			&& resp.data[BIT_RQS])
		else $error("first Read STB did not report the request bit");

	read_clears_a: assert property (@(posedge mclk) disable iff (rst)
		(readStb && !summaryRise) ##1 (readStb && !summaryRise) |=> !resp.data[BIT_RQS])
		else $error("second Read STB still reports the request bit");

	query_keeps_a: assert property (@(posedge mclk) disable iff (rst)
		(stbQuery && !readStb && st.rqsLatch) |=> st.rqsLatch)
		else $error("status query cleared the request latch");

	query_live_a: assert property (@(posedge mclk) disable iff (rst)
		(stbQuery && !readStb) |=> resp.kind == SBSR_ANS_QUERY
			&& resp.data[BIT_RQS] == $past(summaryLive)
			&& (resp.data & 8'hbf) == $past(statusByte))
		else $error("status query answer does not match the live byte");

	mask_inert_a: assert property (@(posedge mclk) disable iff (rst)
		((statusByte & st.mask & 8'h34) == 8'h00) |-> !summaryLive)
		else $error("summary set by a mask bit that cannot raise requests");

	mask_query_a: assert property (@(posedge mclk) disable iff (rst)
		maskWrite ##1 (maskQuery && !stbQuery && !readStb && !maskWrite)
			|=> resp.data == ($past(maskData, 2) & 8'hbf))
		else $error("mask query does not return the written mask");

	mask_bit6_a: assert property (@(posedge mclk) disable iff (rst)
		!st.mask[BIT_RQS])
		else $error("mask bit 6 reads as set");

	// a rise sets the latch and the pulse together, whatever else happens
	pending_set_a: assert property (@(posedge mclk) disable iff (rst)
		summaryRise |=> reqPending && reqTrue)
		else $error("new summary did not set the pending request");

	// a Read STB with no new rise clears the latch on its own edge
	pending_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(readStb && !summaryRise) |=> !reqPending)
		else $error("Read STB left the request pending");

	// nothing but a Read STB may drop the latch; queries leave it alone
	pending_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(st.rqsLatch && !readStb) |=> reqPending)
		else $error("pending request dropped without a Read STB");

	// every answer traces back to a command on the previous edge
	answer_cause_a: assert property (@(posedge mclk) disable iff (rst)
		resp.valid |-> $past(readStb || stbQuery || maskQuery))
		else $error("answer given with no command");

	// colliding reads: the destructive read is the one answered
	read_first_a: assert property (@(posedge mclk) disable iff (rst)
		(readStb && (stbQuery || maskQuery)) |=> resp.kind == SBSR_ANS_READ)
		else $error("Read STB lost to a colliding query");

	// apart from bit 6, Read STB returns the same byte as the query
	read_byte_a: assert property (@(posedge mclk) disable iff (rst)
		readStb |=> (resp.data & 8'hbf) == $past(statusByte))
		else $error("Read STB answer does not match the status byte");

	// the written mask lands on the next edge with bit 6 dropped
	mask_write_a: assert property (@(posedge mclk) disable iff (rst)
		maskWrite |=> st.mask == ($past(maskData) & 8'hbf))
		else $error("mask write did not land");

	// a new level is only taken once the last two stages agree, so a
	// switch caught mid-change never shows up as a false level
	level_accept_a: assert property (@(posedge mclk) disable iff (rst)
		(reqLevel != $past(reqLevel)) |-> ($past(st.lvlS2) == $past(st.lvlS3))
			&& reqLevel == $past(st.lvlS3))
		else $error("interrupt level changed before the switch settled");

endmodule : sbsr_top

// file: shared/sbsr_pkg.sv
// shared constants and carrier types for the status byte and service request block
package sbsr_pkg;

	// field positions inside the status summary byte
	localparam int BIT_ERRQ = 2; // error/event queue not empty
	localparam int BIT_OUTQ = 4; // output buffer holds a response
	localparam int BIT_EVT  = 5; // masked standard event summary
	localparam int BIT_RQS  = 6; // request summary bit

	// reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] STB_RESET  = 8'h00;
	localparam logic [2:0] LVL_RESET  = 3'h0;

	// mask bits that can raise a request; everything else is ignored
	localparam logic [7:0] MASK_LIVE_BITS = 8'h34;
	// bit 6 of the mask is never stored and always reads zero
	localparam logic [7:0] MASK_STORE_BITS = 8'hbf;

	// which command produced an answer
	typedef enum logic [1:0] {
		SBSR_ANS_NONE  = 2'h0,
		SBSR_ANS_READ  = 2'h1, // bus-level Read STB, destructive on bit 6
		SBSR_ANS_QUERY = 2'h3, // status byte query, non-destructive
		SBSR_ANS_MASK  = 2'h2  // mask query
	} sbsr_ans_t;

	// condition sources gathered into the status byte
	typedef struct packed {
		logic       errNotEmpty; // error/event queue holds an entry
		logic       outNotEmpty; // output buffer holds a response
		logic [7:0] eventStatus; // standard event status register
		logic [7:0] eventEnable; // standard event status enable register
	} sbsr_cond_t;

	// one answer to a command
	typedef struct packed {
		logic       valid;
		sbsr_ans_t  kind;
		logic [7:0] data;
	} sbsr_resp_t;

endpackage : sbsr_pkg

// file: rtl/sbsr_byte_build.sv
// builds the registered status summary byte from its condition sources
`timescale 1ns/1ns
module sbsr_byte_build
	import sbsr_pkg::*;
(
	input  wire logic       mclk,       // 10 MHz system clock
	input  wire logic       rst,        // asynchronous reset, active high
	input  wire sbsr_cond_t cond,       // condition sources, same clock domain
	output logic [7:0]      statusByte  // status byte, bit 6 left zero here
);

	typedef struct packed {
		logic [7:0] stb;
	} sbsr_build_state_t;

	sbsr_build_state_t st;
	sbsr_build_state_t next_st;

	// unused bits stay zero so they can never feed the request summary
	always_comb
	begin
		next_st = st;
		next_st.stb = STB_RESET;
		next_st.stb[BIT_ERRQ] = cond.errNotEmpty;
		next_st.stb[BIT_OUTQ] = cond.outNotEmpty;
		next_st.stb[BIT_EVT]  = |(cond.eventStatus & cond.eventEnable);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st <= '{stb: STB_RESET};
		else
			st <= next_st;
	end

	assign statusByte = st.stb;

	// the byte follows its sources one cycle later
	errq_follow_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) |-> statusByte[BIT_ERRQ] == $past(cond.errNotEmpty))
		else $error("error queue bit does not follow its source");
	outq_follow_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(cond.outNotEmpty) |=> statusByte[BIT_OUTQ])
		else $error("output buffer bit missed a new response");
	evt_summary_a: assert property (@(posedge mclk) disable iff (rst)
		(cond.eventStatus & cond.eventEnable) == 8'h00 |=> !statusByte[BIT_EVT])
		else $error("event summary bit set with no enabled event");
	unused_zero_a: assert property (@(posedge mclk) disable iff (rst)
		(statusByte & 8'hcb) == 8'h00)
		else $error("unused status bit is not zero");

endmodule : sbsr_byte_build

// file: verif/sbsr_commander.sv
// commander model that issues the command pulses toward the block
`timescale 1ns/1ns
module sbsr_commander
	import sbsr_pkg::*;
(
	input  wire logic  mclk,      // system clock
	output logic       maskWrite, // mask-setting pulse
	output logic [7:0] maskData,  // mask value with maskWrite
	output logic       maskQuery, // mask query pulse
	output logic       stbQuery,  // status query pulse
	output logic       readStb    // bus Read STB pulse
);
	// every pulse idles low from time zero
	initial {maskWrite, maskData, maskQuery, stbQuery, readStb} = '0;

	// called at a falling edge: sel is {maskWrite, maskQuery, stbQuery, readStb}
	task issue(input logic [3:0] sel, input logic [7:0] m);
	begin
		{maskWrite, maskQuery, stbQuery, readStb} = sel;
		maskData = m;
		@(negedge mclk);
		{maskWrite, maskQuery, stbQuery, readStb} = 4'h0;
		maskData = ~m; // stale data flipped so a late sample shows up
	end
	endtask : issue

	// two commands on consecutive edges with no idle cycle between them
	task issue_pair(input logic [3:0] selA, input logic [7:0] m, input logic [3:0] selB);
	begin
		{maskWrite, maskQuery, stbQuery, readStb} = selA;
		maskData = m;
		@(negedge mclk);
		{maskWrite, maskQuery, stbQuery, readStb} = selB;
		maskData = ~m;
		@(negedge mclk);
		{maskWrite, maskQuery, stbQuery, readStb} = 4'h0;
	end
	endtask : issue_pair
endmodule : sbsr_commander

// file: verif/tb_status_byte_service_request.sv
// self-checking bench for the status byte and service request block
`timescale 1ns/1ns
module tb_status_byte_service_request import sbsr_pkg::*;;
	logic       mclk = 1'b0;
	logic       rst;
	sbsr_cond_t cond;
	logic [2:0] levelPins;
	logic       maskWrite, maskQuery, stbQuery, readStb;
	logic [7:0] maskData;
	sbsr_resp_t resp;
	logic       reqTrue, reqPending;
	logic [2:0] reqLevel;
	int         fails = 0, testsRun = 0, pulses = 0, rises = 0;
	int         seed = 32'h088508d1;
	logic [31:0] r;
	logic [7:0] sb, md;
	logic       live, prevLive, latch;

	always #50 mclk = ~mclk;

	// count request-true pulses at the falling edge, where the port is settled
	always @(negedge mclk)
		if (reqTrue === 1'b1)
			pulses++;

	sbsr_top sbsr_top_inst (.mclk(mclk), .rst(rst), .cond(cond), .maskWrite(maskWrite),
		.maskData(maskData), .maskQuery(maskQuery), .stbQuery(stbQuery), .readStb(readStb),
		.levelPins(levelPins), .resp(resp), .reqTrue(reqTrue), .reqLevel(reqLevel),
		.reqPending(reqPending));

	sbsr_commander sbsr_commander_inst (.mclk(mclk), .maskWrite(maskWrite),
		.maskData(maskData), .maskQuery(maskQuery), .stbQuery(stbQuery), .readStb(readStb));

	task chk(input logic [10:0] got, input logic [10:0] exp);
	begin
		testsRun++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask : chk

	// one command, answer sampled in the cycle it stands; an idle edge
	// follows so the next pulse is never raised in the same time step
	task ask(input logic [3:0] sel, input logic [1:0] k, input logic [7:0] e);
	begin
		sbsr_commander_inst.issue(sel, 8'h00);
		chk(resp, {1'b1, k, e});
		@(negedge mclk);
	end
	endtask : ask

	task report_and_stop;
	begin
		$display("comparisons %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask : report_and_stop

	// watchdog: the run needs well under 1000 cycles
	initial
	begin
		#(100 * 3000);
		fails++;
		report_and_stop;
	end

	initial
	begin
		rst = 1'b1;
		cond = '0;
		levelPins = 3'h0;
		prevLive = 1'b0;
		latch = 1'b0;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge mclk);
			r = $random(seed);
			cond = r[17:0];
			md = r[25:18];
			levelPins = r[28:26];
			// cond and mask change together so the summary moves once
			sbsr_commander_inst.issue(4'h8, md);
			sb = {2'b00, |(cond.eventStatus & cond.eventEnable), cond.outNotEmpty, 1'b0,
				cond.errNotEmpty, 2'b00};
			live = |(sb & md & 8'h34);
			if (live && !prevLive)
			begin
				rises++;
				latch = 1'b1;
			end
			prevLive = live;
			repeat (4) @(negedge mclk);
			chk({7'h00, reqLevel, reqPending}, {7'h00, levelPins, latch});
			ask(4'h2, 2'h3, sb | {1'b0, live, 6'h00});
			ask(4'h1, 2'h1, sb | {1'b0, latch, 6'h00});
			latch = 1'b0;
			ask(4'h1, 2'h1, sb);
			ask(4'h4, 2'h2, md & 8'hbf);
		end
		// all three reads at once: the Read STB is the one answered
		ask(4'h7, 2'h1, sb);
		$display("test random status and mask done");
		// back to back: mask write then mask query, then two Read STB in a row
		@(negedge mclk);
		cond = '{1'b1, 1'b1, 8'h00, 8'h00}; // both queues hold entries, no event
		sbsr_commander_inst.issue_pair(4'h8, 8'h00, 4'h4);
		chk(resp, {1'b1, 2'h2, 8'h00});
		@(negedge mclk);
		sbsr_commander_inst.issue_pair(4'h8, 8'hf4, 4'h4);
		rises++; // mask 0x34 part against byte 0x14 makes a new summary
		chk(resp, {1'b1, 2'h2, 8'hb4});
		chk({7'h00, reqLevel, reqPending}, {7'h00, levelPins, 1'b1});
		@(negedge mclk);
		fork
			sbsr_commander_inst.issue_pair(4'h1, 8'h00, 4'h1);
			begin
				@(negedge mclk);
				chk(resp, {1'b1, 2'h1, 8'h54});
			end
		join
		chk(resp, {1'b1, 2'h1, 8'h14});
		chk(11'(pulses), 11'(rises));
		$display("test back to back commands done");
		report_and_stop;
	end
endmodule : tb_status_byte_service_request
